// ===== ladder_ctrl_consts.svh
// constants for the comparator reference ladder control block
`ifndef LADDER_CTRL_CONSTS_SVH
`define LADDER_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets on the axi4-lite bus
// ----------------------------------------------------------------
`define LADDER_CTRL_OFFSET 12'h000
`define LADDER_STATUS_OFFSET 12'h004

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define LADDER_POWER_BIT 7
`define LADDER_PIN_OE_BIT 6
`define LADDER_RANGE_BIT 5
`define LADDER_SOURCE_BIT 4
`define LADDER_CODE_MSB 3
`define LADDER_CODE_LSB 0
`define LADDER_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define LADDER_STAT_LEVEL_MSB 6
`define LADDER_STAT_PIN_BIT 8

// ----------------------------------------------------------------
// ladder scale: levels are expressed in 96ths of the source span
// ----------------------------------------------------------------
`define LADDER_SCALE_DEN 96
`define LADDER_ZERO_RANGE_STEP 7'h04
`define LADDER_QUARTER_RANGE_STEP 7'h03
`define LADDER_QUARTER_OFFSET 7'h08

// ----------------------------------------------------------------
// axi response codes
// ----------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ===== ladder_ctrl_pkg.sv
// types shared by the comparator reference ladder control block
package ladder_ctrl_pkg;

    // read channel sequencing
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_e;

    // one byte of ladder control
    typedef logic [7:0] ctrl_byte_t;

    // level in 96ths of the source span
    typedef logic [6:0] level_t;

endpackage : ladder_ctrl_pkg

// ===== ladder_ctrl_reg.sv
// the eight-bit ladder control register with its reset and write update
`include "ladder_ctrl_consts.svh"

module ladder_ctrl_reg
    import ladder_ctrl_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    // write port
    input wire logic i_wr_en,
    input wire ctrl_byte_t i_wr_data,
    // stored value
    output ctrl_byte_t o_ctrl
);

    ctrl_byte_t ctrl_reg; // stored control byte
    ctrl_byte_t ctrl_next; // value for the next edge

    // next value: whole byte replaced at once on a write
    always_comb begin
        ctrl_next = i_wr_en ? i_wr_data : ctrl_reg; // R13
    end

    // only reset or a write alters the byte, so waking from sleep keeps it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= `LADDER_CTRL_RESET; // R8
        end else if (i_clk_en) begin
            ctrl_reg <= ctrl_next; // R9
        end
    end

    assign o_ctrl = ctrl_reg;

endmodule : ladder_ctrl_reg

// ===== ladder_tap_decode.sv
// maps level code and range onto a ladder tap in 96ths of the span
`include "ladder_ctrl_consts.svh"

module ladder_tap_decode
    import ladder_ctrl_pkg::*;
(
    // control fields
    input wire logic [3:0] i_code,
    input wire logic i_range,
    input wire logic i_power,
    // decoded tap
    output level_t o_level
);

    // ----------------------------------------------------------------
    // tap arithmetic
    // ----------------------------------------------------------------
    // zero range: code/24 = 4*code/96; quarter range: (8+code)/32 = 3*(8+code)/96
    function automatic level_t tap_level(input logic [3:0] code, input logic range);
        level_t c;
        c = {3'h0, code};
        if (range) begin
            tap_level = 7'(c * `LADDER_ZERO_RANGE_STEP); // R2
        end else begin
            tap_level = 7'((c + `LADDER_QUARTER_OFFSET) * `LADDER_QUARTER_RANGE_STEP); // R3
        end
    endfunction : tap_level

    // a powered-down ladder presents no tap
    assign o_level = i_power ? tap_level(i_code, i_range) : 7'h00; // R4

endmodule : ladder_tap_decode

// ===== ladder_ctrl_top.sv
// axi4-lite controlled reference ladder: register slave, decode and pin gating
//
// Function
// R1: four-bit code picks sixteen levels per range
// R2: range one gives code over 24
// R3: range zero gives quarter plus code/32
// R4: bit 7 powers the ladder on/off
// R5: bit 6 drives level onto shared pin
// R6: bit 5 selects zero or quarter range
// R7: bit 4 selects external pins or supply
// R8: reset clears the whole register to zero
// R9: wake from sleep keeps every field
// R10: pin connects only when input and enabled
// R11: independent of comparator configuration
// R12: software should power down before sleep
// R13: write updates all; read returns all bits
//
// The AXI4-Lite register port and the address map were decided locally.
`include "ladder_ctrl_consts.svh"

module ladder_ctrl_top
    import ladder_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12 // byte address width of the slave
) (
    // clock, enable, reset
    input wire logic i_clk,
    input wire logic i_clk_en,
    input wire logic i_rst_b,
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // port logic on the same clock
    input wire logic i_shared_pin_direction,
    // analog ladder controls
    output logic o_ladder_power_enable,
    output logic o_ladder_range_select,
    output logic o_ladder_source_select,
    output logic [3:0] o_ladder_level_code,
    output level_t o_ladder_output_level,
    output logic o_shared_analog_pin_connect
);

    // ----
    // declarations
    // ----
    ctrl_byte_t ctrl; // stored control byte
    level_t tap_level; // decoded tap, combinational
    logic wr_ctrl_en; // one-cycle write strobe to the control byte
    logic pin_connect; // combinational pin gate

    // write channel state
    logic awready_reg; // address channel ready
    logic awready_next;
    logic wready_reg; // data channel ready
    logic wready_next;
    logic aw_got_reg; // address held, waiting for data
    logic aw_got_next;
    logic w_got_reg; // data held, waiting for address
    logic w_got_next;
    logic [ADDR_W-1:0] waddr_reg; // held write address
    logic [ADDR_W-1:0] waddr_next;
    logic [7:0] wbyte_reg; // held low data byte
    logic [7:0] wbyte_next;
    logic wlane_reg; // low byte lane enabled
    logic wlane_next;
    logic bvalid_reg; // response pending
    logic bvalid_next;
    logic [1:0] bresp_reg; // response code
    logic [1:0] bresp_next;

    // read channel state
    rd_state_e rd_state_reg; // read sequencing
    rd_state_e rd_state_next;
    logic [31:0] rdata_reg; // read data held for the master
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg; // read response code
    logic [1:0] rresp_next;

    // registered ladder outputs
    logic power_reg;
    logic power_next;
    logic range_reg;
    logic range_next;
    logic source_reg;
    logic source_next;
    logic [3:0] code_reg;
    logic [3:0] code_next;
    level_t level_reg;
    level_t level_next;
    logic pin_reg;
    logic pin_next;

    // ----
    // address decode
    // ----
    // word aligned match; the low two address bits are ignored
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                     input logic [11:0] offset);
        addr_is = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
    endfunction : addr_is

    // ----
    // control register and tap decode
    // ----
    // the byte has no input from comparator configuration at all
    ladder_ctrl_reg u_ctrl_reg (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .i_wr_en(wr_ctrl_en),
        .i_wr_data(wbyte_reg),
        .o_ctrl(ctrl)
    ); // R11

    // code field spans sixteen taps in either range
    ladder_tap_decode u_tap (
        .i_code(ctrl[`LADDER_CODE_MSB:`LADDER_CODE_LSB]), // R1
        .i_range(ctrl[`LADDER_RANGE_BIT]), // R6
        .i_power(ctrl[`LADDER_POWER_BIT]),
        .o_level(tap_level)
    );

    // ----
    // shared pin gating
    // ----
    // direction high means input; the ladder must be powered to drive anything
    always_comb begin
        pin_connect = ctrl[`LADDER_POWER_BIT]
                    & ctrl[`LADDER_PIN_OE_BIT] // R5
                    & i_shared_pin_direction; // R10
    end

    // ----
    // write channels: next state
    // ----
    // address and data in either order; write and response land one edge after both
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        waddr_next = waddr_reg;
        wbyte_next = wbyte_reg;
        wlane_next = wlane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        wr_ctrl_en = 1'b0;
        // response accepted by the master
        if (bvalid_reg && i_bready) begin
            bvalid_next = 1'b0;
        end
        // write address taken
        if (i_awvalid && awready_reg) begin
            aw_got_next = 1'b1;
            waddr_next = i_awaddr;
        end
        // write data taken
        if (i_wvalid && wready_reg) begin
            w_got_next = 1'b1;
            wbyte_next = i_wdata[7:0];
            wlane_next = i_wstrb[0];
        end
        // both halves present and no response outstanding
        if (aw_got_reg && w_got_reg && !bvalid_reg) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            if (addr_is(waddr_reg, `LADDER_CTRL_OFFSET)) begin
                // a cleared low lane leaves the byte alone but still answers okay
                wr_ctrl_en = wlane_reg; // R13
                bresp_next = `AXI_RESP_OKAY;
            end else if (addr_is(waddr_reg, `LADDER_STATUS_OFFSET)) begin
                // status is read only; writes are dropped quietly
                bresp_next = `AXI_RESP_OKAY;
            end else begin
                // unmapped address
                bresp_next = `AXI_RESP_SLVERR;
            end
        end
        // channels reopen only once the previous write is fully answered
        awready_next = !aw_got_next && !bvalid_next;
        wready_next = !w_got_next && !bvalid_next;
    end

    // ----
    // write channels: registers
    // ----
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `AXI_RESP_OKAY;
        end else if (i_clk_en) begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            waddr_reg <= waddr_next;
            wbyte_reg <= wbyte_next;
            wlane_reg <= wlane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // ----
    // read channel: next state
    // ----
    // data captured at the address edge misses a write landing on that edge
    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_state_reg)
            RD_IDLE: begin
                if (i_arvalid) begin
                    rd_state_next = RD_RESP;
                    rresp_next = `AXI_RESP_OKAY;
                    if (addr_is(i_araddr, `LADDER_CTRL_OFFSET)) begin
                        rdata_next = {24'h000000, ctrl}; // R13
                    end else if (addr_is(i_araddr, `LADDER_STATUS_OFFSET)) begin
                        // live tap and pin state
                        rdata_next = {23'h000000, pin_connect, 1'b0, tap_level};
                    end else begin
                        // unmapped: zero data with slave error
                        rdata_next = 32'h00000000;
                        rresp_next = `AXI_RESP_SLVERR;
                    end
                end
            end
            RD_RESP: begin
                // hold data until the master takes it
                if (i_rready) begin
                    rd_state_next = RD_IDLE;
                end
            end
            default: begin
                rd_state_next = RD_IDLE;
            end
        endcase
    end

    // ----
    // read channel: registers
    // ----
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_state_reg <= RD_IDLE;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `AXI_RESP_OKAY;
        end else if (i_clk_en) begin
            rd_state_reg <= rd_state_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ----
    // ladder outputs: next state
    // ----
    // registered so analog controls never glitch; sleep is not watched here
    always_comb begin
        power_next = ctrl[`LADDER_POWER_BIT]; // R4
        range_next = ctrl[`LADDER_RANGE_BIT]; // R6
        source_next = ctrl[`LADDER_SOURCE_BIT]; // R7
        code_next = ctrl[`LADDER_CODE_MSB:`LADDER_CODE_LSB]; // R1
        level_next = tap_level; // R2
        pin_next = pin_connect; // R10
    end

    // ----
    // ladder outputs: registers
    // ----
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            power_reg <= 1'b0;
            range_reg <= 1'b0;
            source_reg <= 1'b0;
            code_reg <= 4'h0;
            level_reg <= 7'h00;
            pin_reg <= 1'b0;
        end else if (i_clk_en) begin
            power_reg <= power_next;
            range_reg <= range_next;
            source_reg <= source_next;
            code_reg <= code_next;
            level_reg <= level_next;
            pin_reg <= pin_next;
        end
    end

    // ----
    // output wiring, all from flip-flops
    // ----
    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bvalid = bvalid_reg;
    assign o_bresp = bresp_reg;
    assign o_arready = (rd_state_reg == RD_IDLE);
    assign o_rvalid = (rd_state_reg == RD_RESP);
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_ladder_power_enable = power_reg;
    assign o_ladder_range_select = range_reg;
    assign o_ladder_source_select = source_reg;
    assign o_ladder_level_code = code_reg;
    assign o_ladder_output_level = level_reg;
    assign o_shared_analog_pin_connect = pin_reg;

endmodule : ladder_ctrl_top

// ===== ladder_analog_model.sv
// behavioural model of the analog ladder and the shared pin it can drive
module ladder_analog_model #(
    parameter int SUP_MV = 3264, // supply span, a multiple of 96 keeps taps exact
    parameter int EXT_MV = 2400 // external pin span, also a multiple of 96
) (
    // control from the block
    input wire logic i_power,
    input wire logic i_source,
    input wire logic [6:0] i_level,
    input wire logic i_connect,
    // analog results in millivolts
    output logic [31:0] o_ref_mv,
    output logic [31:0] o_pin_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // ladder tap voltage, ground while unpowered
    // ----
    assign o_ref_mv = i_power ? 32'((i_source ? EXT_MV : SUP_MV) * i_level / 96) : 32'h0;
    // pin has a pull-down here, so a released pin reads ground, not the old level
    assign o_pin_mv = i_connect ? o_ref_mv : 32'h0;
endmodule : ladder_analog_model

// ===== ladder_ctrl_top_checker.sv
// port assertions for the reference ladder control top
`include "ladder_ctrl_consts.svh"

module ladder_ctrl_top_checker
    import ladder_ctrl_pkg::*;
#(
    parameter int ADDR_W = 12 // byte address width of the slave
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // write channels
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic o_bvalid,
    input wire logic [1:0] o_bresp,
    // ladder side
    input wire logic i_shared_pin_direction,
    input wire logic o_ladder_power_enable,
    input wire logic o_ladder_range_select,
    input wire logic o_ladder_source_select,
    input wire logic [3:0] o_ladder_level_code,
    input wire level_t o_ladder_output_level,
    input wire logic o_shared_analog_pin_connect
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // helpers
    // ----
    logic wr_go; // both write halves taken together
    assign wr_go = i_awvalid && o_awready && i_wvalid && o_wready;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ----
    // properties
    // ----
    property p_reset_clear;
        $rose(i_rst_b) |-> !o_ladder_power_enable && !o_ladder_range_select
            && !o_ladder_source_select && o_ladder_level_code == 4'h0
            && o_ladder_output_level == 7'h00 && !o_shared_analog_pin_connect;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear");
    property p_level_off;
        !o_ladder_power_enable |-> o_ladder_output_level == 7'h00;
    endproperty
    a_level_off: assert property (p_level_off) else $error("level while off");
    property p_level_zero;
        o_ladder_power_enable && o_ladder_range_select
            |-> o_ladder_output_level == 7'(4 * o_ladder_level_code);
    endproperty
    a_level_zero: assert property (p_level_zero) else $error("zero range tap");
    property p_level_quarter;
        o_ladder_power_enable && !o_ladder_range_select
            |-> o_ladder_output_level == 7'(3 * (8 + o_ladder_level_code));
    endproperty
    a_level_quarter: assert property (p_level_quarter) else $error("quarter tap");
    property p_pin;
        o_shared_analog_pin_connect |-> o_ladder_power_enable && $past(i_shared_pin_direction);
    endproperty
    a_pin: assert property (p_pin) else $error("pin connected wrongly");
    property p_write_resp;
        wr_go |-> ##2 o_bvalid && o_bresp == (($past(i_awaddr, 2) inside
            {`LADDER_CTRL_OFFSET, `LADDER_STATUS_OFFSET}) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR);
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response");
    property p_write_update;
        wr_go && i_awaddr == `LADDER_CTRL_OFFSET && i_wstrb[0] |-> ##3 {o_ladder_power_enable,
            o_ladder_range_select, o_ladder_source_select, o_ladder_level_code}
            == $past({i_wdata[7], i_wdata[5:0]}, 3);
    endproperty
    a_write_update: assert property (p_write_update) else $error("fields not updated");
    property p_hold;
        $changed({o_ladder_level_code, o_ladder_power_enable, o_ladder_range_select,
            o_ladder_source_select}) |-> $past(o_bvalid);
    endproperty
    a_hold: assert property (p_hold) else $error("field moved without write");
endmodule : ladder_ctrl_top_checker

bind ladder_ctrl_top ladder_ctrl_top_checker #(.ADDR_W(ADDR_W)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata),
    .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .o_bresp(o_bresp),
    .i_shared_pin_direction(i_shared_pin_direction),
    .o_ladder_power_enable(o_ladder_power_enable), .o_ladder_range_select(o_ladder_range_select),
    .o_ladder_source_select(o_ladder_source_select), .o_ladder_level_code(o_ladder_level_code),
    .o_ladder_output_level(o_ladder_output_level),
    .o_shared_analog_pin_connect(o_shared_analog_pin_connect));

// ===== ladder_ctrl_top_tb.sv
// self-checking bench for the reference ladder control block
`include "ladder_ctrl_consts.svh"

module ladder_ctrl_top_tb import ladder_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // signals
    // ----
    localparam int SUP_MV = 3264; // supply span in millivolts
    localparam int EXT_MV = 2400; // external span in millivolts
    localparam logic [11:0] BAD_A [3] = '{12'h000, 12'h008, 12'h004}; // refused writes
    localparam logic [3:0] BAD_S [3] = '{4'hE, 4'hF, 4'hF}; // their strobes
    localparam logic [1:0] BAD_R [3] = '{2'h0, 2'h2, 2'h0}; // their responses
    logic i_clk, i_rst_b, awvalid, wvalid, bready, arvalid, rready, pin_dir;
    logic awready, wready, bvalid, arready, rvalid, pwr, rng, src, conn;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ref_mv, pin_mv, seed;
    logic [3:0] wstrb, code;
    logic [1:0] bresp, rresp;
    level_t level;
    int mismatches, samples_checked;
    // ----
    // design and far side
    // ----
    ladder_ctrl_top #(.ADDR_W(12)) dut (
        .i_clk(i_clk), .i_clk_en(1'b1), .i_rst_b(i_rst_b),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_shared_pin_direction(pin_dir), .o_ladder_power_enable(pwr),
        .o_ladder_range_select(rng), .o_ladder_source_select(src),
        .o_ladder_level_code(code), .o_ladder_output_level(level),
        .o_shared_analog_pin_connect(conn));
    ladder_analog_model #(.SUP_MV(SUP_MV), .EXT_MV(EXT_MV)) far (
        .i_power(pwr), .i_source(src), .i_level(level), .i_connect(conn),
        .o_ref_mv(ref_mv), .o_pin_mv(pin_mv));
    // 125 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // ----
    // expectations
    // ----
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    function automatic logic [6:0] exp_level(input logic [7:0] d);
        if (!d[7]) return 7'h00;
        return d[5] ? 7'(4 * d[3:0]) : 7'(3 * (8 + d[3:0]));
    endfunction : exp_level
    // millivolts from the ladder formulas
    function automatic logic [31:0] exp_mv(input logic [7:0] d);
        int span;
        span = d[4] ? EXT_MV : SUP_MV;
        if (!d[7]) return 32'h0;
        if (d[5]) return 32'(d[3:0] * span / 24);
        return 32'(span / 4 + d[3:0] * span / 32);
    endfunction : exp_mv
    // ----
    // compare, close and bus tasks
    // ----
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check_val({30'h0, got}, {30'h0, exp});
    endtask : check_resp
    task automatic complete_run();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // one bounded clock step; a hang counts as a mismatch
    task automatic step(inout int n);
        @(posedge i_clk);
        n++;
        if (n > 60) begin
            mismatches++;
            complete_run();
        end
    endtask : step
    // ladder outputs and analog result for byte d
    task automatic check_outputs(input logic [7:0] d);
        logic c;
        #1;
        c = d[7] & d[6] & pin_dir;
        check_val({pwr, rng, src, code, level, conn}, {d[7], d[5:0], exp_level(d), c});
        check_val(ref_mv, exp_mv(d));
        check_val(pin_mv, c ? exp_mv(d) : 32'h0);
    endtask : check_outputs
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clk);
        {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'h7, a, d, s};
        do begin
            step(n);
            if (awready) awvalid <= 1'b0; // address taken
            if (wready) wvalid <= 1'b0; // data taken
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_clk);
        {arvalid, rready, araddr} <= {2'h3, a};
        do begin
            step(n);
            if (arready) arvalid <= 1'b0; // address taken
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // ----
    // main sequence
    // ----
    initial begin
        logic [7:0] d;
        logic [31:0] rd;
        logic [1:0] rs;
        mismatches = 0;
        samples_checked = 0;
        seed = 32'h44DD11F9;
        {i_rst_b, awvalid, wvalid, bready, arvalid, rready, pin_dir} = 7'h00;
        {awaddr, araddr, wdata, wstrb} = 60'h0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        check_outputs(8'h00);
        // all codes in both ranges, then random bytes
        for (int i = 0; i < 48; i++) begin
            seed = xorshift(seed);
            d = (i < 32) ? {1'b1, seed[6], i[4], seed[4], i[3:0]} : seed[7:0];
            @(posedge i_clk);
            pin_dir <= seed[9];
            axi_write(`LADDER_CTRL_OFFSET, {seed[31:8], d}, {seed[12:10], 1'b1}, rs);
            check_resp(rs, `AXI_RESP_OKAY);
            check_outputs(d);
            repeat (3) @(posedge i_clk);
            axi_read(`LADDER_CTRL_OFFSET, rd, rs);
            check_val(rd, {24'h0, d});
            axi_read(`LADDER_STATUS_OFFSET, rd, rs);
            check_val(rd, {23'h0, d[7] & d[6] & pin_dir, 1'b0, exp_level(d)});
        end
        // refused writes leave the byte alone
        for (int k = 0; k < 3; k++) begin
            axi_write(BAD_A[k], 32'hFF, BAD_S[k], rs);
            check_resp(rs, BAD_R[k]);
            check_outputs(d);
        end
        axi_read(12'h008, rd, rs);
        check_val(rd, 32'h0);
        check_resp(rs, `AXI_RESP_SLVERR);
        // reset in mid-run clears everything
        axi_write(`LADDER_CTRL_OFFSET, 32'hFF, 4'h1, rs);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        check_outputs(8'h00);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        axi_read(`LADDER_CTRL_OFFSET, rd, rs);
        check_val(rd, 32'h0);
        // software powers the ladder down before sleeping
        axi_write(`LADDER_CTRL_OFFSET, 32'h0, 4'h1, rs);
        check_outputs(8'h00);
        complete_run();
    end
endmodule : ladder_ctrl_top_tb
